// ### design/calu_pkg.sv
// Package of opcodes, sizes, flag layout and request/answer carriers
package calu_pkg;

    localparam int unsigned DATA_W   = 32;
    localparam int unsigned HALF_W   = 16;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned REG_CNT  = 8;
    localparam int unsigned REG_IDX_W = 3;
    localparam int unsigned BITNO_W  = 3;
    localparam int unsigned DIV_STEPS_W = 6;

    // Flag positions in the condition flags register
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_V = 1;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_W = 4;
    localparam logic [3:0]  FLAGS_RESET = 4'h0;

    typedef enum logic [1:0] {
        CALU_SZ_B = 2'b00,
        CALU_SZ_W = 2'b01,
        CALU_SZ_L = 2'b10
    } calu_size_type;

    typedef enum logic [4:0] {
        CALU_OP_UDIV  = 5'b00000,
        CALU_OP_SDIV  = 5'b00001,
        CALU_OP_COMP  = 5'b00010,
        CALU_OP_NEG   = 5'b00011,
        CALU_OP_SEXT  = 5'b00100,
        CALU_OP_ZEXT  = 5'b00101,
        CALU_OP_AND   = 5'b00110,
        CALU_OP_OR    = 5'b00111,
        CALU_OP_XOR   = 5'b01000,
        CALU_OP_NOT   = 5'b01001,
        CALU_OP_ASL   = 5'b01010,
        CALU_OP_ASR   = 5'b01011,
        CALU_OP_LSL   = 5'b01100,
        CALU_OP_LSR   = 5'b01101,
        CALU_OP_ROL   = 5'b01110,
        CALU_OP_ROR   = 5'b01111,
        CALU_OP_ROLC  = 5'b10000,
        CALU_OP_RORC  = 5'b10001,
        CALU_OP_SETB  = 5'b10010,
        CALU_OP_CLRB  = 5'b10011,
        CALU_OP_BINV  = 5'b10100,
        CALU_OP_TSTB  = 5'b10101,
        CALU_OP_BAND  = 5'b10110,
        CALU_OP_IBAND = 5'b10111
    } calu_op_type;

    typedef enum logic [1:0] {
        CALU_ST_IDLE = 2'b00,
        CALU_ST_DIV  = 2'b01,
        CALU_ST_DONE = 2'b10
    } calu_state_type;

    // One operation request from the decoder
    typedef struct packed {
        calu_op_type            op;
        calu_size_type          size;
        logic [REG_IDX_W:0]     dst;
        logic [REG_IDX_W:0]     src;
        logic                   use_imm;
        logic [DATA_W-1:0]      imm;
        logic                   bit_from_reg;
        logic [BITNO_W-1:0]     bit_imm;
    } calu_req_type;

    // Condition flags: c, v, z, n
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } calu_flags_type;

endpackage : calu_pkg

// ### design/calu_core.sv
// Arithmetic, logic, shift and bit datapath with its register file and flags
`timescale 1ns/1ps
// Summary of operation
// - Unsigned divide 16/8 gives 8-bit quotient/remainder; 32/16 gives 16-bit each.
// - Signed divide, two's complement, same two shapes as unsigned divide.
// - Compare subtracts source from destination, sets flags, destination unchanged.
// - Negate writes zero minus destination, byte, word or longword.
// - Sign extend copies top bit of low byte/word into upper bits.
// - Zero extend clears upper bits above low byte or low word.
// - AND combines destination with register or immediate into destination.
// - OR combines destination with register or immediate into destination.
// - XOR combines destination with register or immediate into destination.
// - NOT inverts every destination bit at the selected size.
// - Arithmetic shifts move one place; right shift keeps sign bit.
// - Logical shifts move one place and insert zero.
// - Rotates wrap within register or pass through carry flag.
// - Logic, shift, rotate, compare, negate accept byte, word, longword sizes.
// - Bit set forces the selected byte bit to one.
// - Bit clear forces the selected byte bit to zero.
// - Bit invert toggles the selected byte bit.
// - Bit test sets zero flag to inverse of the bit; operand unchanged.
// - Bit number from 3-bit immediate or low three bits of a register.
// - Bit AND with carry replaces carry by carry AND selected bit.
// - Inverted bit AND uses bit complement; bit number from immediate only.
// - Registers seen as sixteen bytes, sixteen words or eight longwords.
module calu_core #(
    parameter int unsigned REG_CNT = calu_pkg::REG_CNT
) (
    input  wire logic                           clk_i,
    input  wire logic                           reset_n_i,
    input  wire logic                           req_valid_i,
    input  wire calu_pkg::calu_req_type         req_i,
    output logic                                req_ready_o,
    output logic                                done_o,
    output calu_pkg::calu_flags_type            flags_o,
    output logic [calu_pkg::DATA_W-1:0]         result_o,
    input  wire logic [calu_pkg::REG_IDX_W-1:0] rd_idx_i,
    output logic [calu_pkg::DATA_W-1:0]         rd_data_o
);

    localparam int unsigned DW = calu_pkg::DATA_W;
    localparam int unsigned HW = calu_pkg::HALF_W;
    localparam int unsigned BW = calu_pkg::BYTE_W;

    // ************************************************************
    // State
    // ************************************************************
    logic [DW-1:0]              regs      [REG_CNT];
    logic [DW-1:0]              next_regs [REG_CNT];
    calu_pkg::calu_flags_type   flags, next_flags;
    calu_pkg::calu_state_type   state, next_state;
    calu_pkg::calu_req_type     cur, next_cur;
    logic [DW-1:0]              result, next_result;
    logic [DW-1:0]              rem, next_rem;
    logic [HW-1:0]              quo, next_quo;
    logic [HW-1:0]              dvs, next_dvs;
    logic [calu_pkg::DIV_STEPS_W-1:0] cnt, next_cnt;
    logic                       qneg, next_qneg;
    logic                       rneg, next_rneg;

    // ************************************************************
    // Register views
    // ************************************************************
    function automatic logic [DW-1:0] rd_view(
        input logic [DW-1:0] r [REG_CNT],
        input logic [calu_pkg::REG_IDX_W:0] idx,
        input calu_pkg::calu_size_type sz);
        logic [DW-1:0] w;
        w = r[idx[calu_pkg::REG_IDX_W-1:0]];
        case (sz)
            calu_pkg::CALU_SZ_B: rd_view = idx[calu_pkg::REG_IDX_W] ?
                                    {24'h0, w[BW-1:0]} : {24'h0, w[HW-1:BW]};
            calu_pkg::CALU_SZ_W: rd_view = idx[calu_pkg::REG_IDX_W] ?
                                    {16'h0, w[DW-1:HW]} : {16'h0, w[HW-1:0]};
            default:             rd_view = w;
        endcase
    endfunction : rd_view

    // Merge only the size-selected lane into the longword
    function automatic logic [DW-1:0] wr_view(
        input logic [DW-1:0] old,
        input logic [DW-1:0] val,
        input logic hi,
        input calu_pkg::calu_size_type sz);
        logic [DW-1:0] w;
        w = old;
        case (sz)
            calu_pkg::CALU_SZ_B: if (hi) w[BW-1:0] = val[BW-1:0];
                                 else    w[HW-1:BW] = val[BW-1:0];
            calu_pkg::CALU_SZ_W: if (hi) w[DW-1:HW] = val[HW-1:0];
                                 else    w[HW-1:0] = val[HW-1:0];
            default:             w = val;
        endcase
        wr_view = w;
    endfunction : wr_view

    function automatic int unsigned width_of(input calu_pkg::calu_size_type sz);
        case (sz)
            calu_pkg::CALU_SZ_B: width_of = BW;
            calu_pkg::CALU_SZ_W: width_of = HW;
            default:             width_of = DW;
        endcase
    endfunction : width_of

    // ************************************************************
    // Operands and single-cycle datapath
    // ************************************************************
    localparam int unsigned BITNO_W_L = calu_pkg::BITNO_W;
    logic [DW-1:0]  dv, sv, srcv, res, mask, diff;
    logic [BITNO_W_L-1:0] bitno;
    int unsigned    w;
    logic           msb, wr_en, cout, sel_bit;
    calu_pkg::calu_flags_type fl;

    always_comb begin
        w     = width_of(req_i.size);
        mask  = (w == DW) ? {DW{1'b1}} : ((DW'(1) << w) - DW'(1));
        dv    = rd_view(regs, req_i.dst, req_i.size);
        srcv  = rd_view(regs, req_i.src, req_i.size);
        sv    = req_i.use_imm ? (req_i.imm & mask) : srcv;
        bitno = (req_i.bit_from_reg && req_i.op != calu_pkg::CALU_OP_IBAND) ?
                srcv[BITNO_W_L-1:0] : req_i.bit_imm;
        sel_bit = dv[bitno];
        msb   = dv[w-1];
        res   = dv;
        wr_en = 1'b1;
        fl    = flags;
        diff  = (dv - sv) & mask;
        cout  = 1'b0;
        case (req_i.op)
            calu_pkg::CALU_OP_COMP: begin
                wr_en = 1'b0;
                fl.c  = sv > dv;
                fl.v  = (dv[w-1] ^ sv[w-1]) & (dv[w-1] ^ diff[w-1]);
                fl.z  = diff == '0;
                fl.n  = diff[w-1];
            end
            calu_pkg::CALU_OP_NEG: begin
                res  = (DW'(0) - dv) & mask;
                fl.c = dv != '0;
                fl.v = dv[w-1] & res[w-1];
            end
            calu_pkg::CALU_OP_SEXT: begin
                res  = (req_i.size == calu_pkg::CALU_SZ_W) ?
                       {16'h0, {BW{dv[BW-1]}}, dv[BW-1:0]} :
                       {{HW{dv[HW-1]}}, dv[HW-1:0]};
                fl.v = 1'b0;
            end
            calu_pkg::CALU_OP_ZEXT: begin
                res  = (req_i.size == calu_pkg::CALU_SZ_W) ?
                       {24'h0, dv[BW-1:0]} : {16'h0, dv[HW-1:0]};
                fl.v = 1'b0;
            end
            calu_pkg::CALU_OP_AND: begin res = dv & sv; fl.v = 1'b0; end
            calu_pkg::CALU_OP_OR:  begin res = dv | sv; fl.v = 1'b0; end
            calu_pkg::CALU_OP_XOR: begin res = dv ^ sv; fl.v = 1'b0; end
            calu_pkg::CALU_OP_NOT: begin res = ~dv & mask; fl.v = 1'b0; end
            calu_pkg::CALU_OP_ASL: begin
                res = (dv << 1) & mask; fl.c = msb; fl.v = msb ^ dv[w-2];
            end
            calu_pkg::CALU_OP_ASR: begin
                res = (dv >> 1) | (DW'(msb) << (w-1)); fl.c = dv[0]; fl.v = 1'b0;
            end
            calu_pkg::CALU_OP_LSL: begin
                res = (dv << 1) & mask; fl.c = msb; fl.v = 1'b0;
            end
            calu_pkg::CALU_OP_LSR: begin
                res = dv >> 1; fl.c = dv[0]; fl.v = 1'b0;
            end
            calu_pkg::CALU_OP_ROL: begin
                res = ((dv << 1) & mask) | DW'(msb); fl.c = msb; fl.v = 1'b0;
            end
            calu_pkg::CALU_OP_ROR: begin
                res = (dv >> 1) | (DW'(dv[0]) << (w-1)); fl.c = dv[0]; fl.v = 1'b0;
            end
            calu_pkg::CALU_OP_ROLC: begin
                res = ((dv << 1) & mask) | DW'(flags.c); fl.c = msb; fl.v = 1'b0;
            end
            calu_pkg::CALU_OP_RORC: begin
                res = (dv >> 1) | (DW'(flags.c) << (w-1)); fl.c = dv[0]; fl.v = 1'b0;
            end
            calu_pkg::CALU_OP_SETB: res = dv | (DW'(1) << bitno);
            calu_pkg::CALU_OP_CLRB: res = dv & ~(DW'(1) << bitno);
            calu_pkg::CALU_OP_BINV: res = dv ^ (DW'(1) << bitno);
            calu_pkg::CALU_OP_TSTB: begin wr_en = 1'b0; fl.z = ~sel_bit; end
            calu_pkg::CALU_OP_BAND: begin wr_en = 1'b0; fl.c = flags.c & sel_bit; end
            calu_pkg::CALU_OP_IBAND: begin wr_en = 1'b0; fl.c = flags.c & ~sel_bit; end
            default: wr_en = 1'b0;
        endcase
        res = res & ((req_i.op == calu_pkg::CALU_OP_SEXT ||
                      req_i.op == calu_pkg::CALU_OP_ZEXT) ? {DW{1'b1}} : mask);
        if (req_i.op inside {calu_pkg::CALU_OP_NEG, calu_pkg::CALU_OP_SEXT,
                             calu_pkg::CALU_OP_ZEXT, calu_pkg::CALU_OP_AND,
                             calu_pkg::CALU_OP_OR, calu_pkg::CALU_OP_XOR,
                             calu_pkg::CALU_OP_NOT, calu_pkg::CALU_OP_ASL,
                             calu_pkg::CALU_OP_ASR, calu_pkg::CALU_OP_LSL,
                             calu_pkg::CALU_OP_LSR, calu_pkg::CALU_OP_ROL,
                             calu_pkg::CALU_OP_ROR, calu_pkg::CALU_OP_ROLC,
                             calu_pkg::CALU_OP_RORC}) begin
            fl.z = (res == '0);
            fl.n = res[(req_i.op == calu_pkg::CALU_OP_SEXT ||
                        req_i.op == calu_pkg::CALU_OP_ZEXT) ?
                       ((req_i.size == calu_pkg::CALU_SZ_W) ? HW-1 : DW-1) : w-1];
        end
    end

    // ************************************************************
    // Divide: restoring, one quotient bit per clock
    // ************************************************************
    logic [DW-1:0] div_abs_d, rem_sh;
    logic [HW-1:0] div_abs_s;
    logic          div_sgn_d, div_sgn_s, is_div, byte_div, trial_ok;
    logic [HW:0]   trial;
    logic [HW-1:0] fin_q, fin_r;

    always_comb begin
        is_div    = req_i.op == calu_pkg::CALU_OP_UDIV || req_i.op == calu_pkg::CALU_OP_SDIV;
        byte_div  = cur.size == calu_pkg::CALU_SZ_B;
        div_sgn_d = 1'b0;
        div_sgn_s = 1'b0;
        div_abs_d = regs[req_i.dst[calu_pkg::REG_IDX_W-1:0]];
        div_abs_s = srcv[HW-1:0];
        if (req_i.size == calu_pkg::CALU_SZ_B) begin
            div_abs_d = {16'h0, div_abs_d[HW-1:0]};
            div_abs_s = {8'h0, srcv[BW-1:0]};
            if (req_i.op == calu_pkg::CALU_OP_SDIV) begin
                div_sgn_d = div_abs_d[HW-1];
                div_sgn_s = srcv[BW-1];
                if (div_sgn_d) div_abs_d = {16'h0, HW'(-div_abs_d[HW-1:0])};
                if (div_sgn_s) div_abs_s = {8'h0, BW'(-srcv[BW-1:0])};
            end
        end else if (req_i.op == calu_pkg::CALU_OP_SDIV) begin
            div_sgn_d = div_abs_d[DW-1];
            div_sgn_s = srcv[HW-1];
            if (div_sgn_d) div_abs_d = -div_abs_d;
            if (div_sgn_s) div_abs_s = -srcv[HW-1:0];
        end
        rem_sh   = {rem[DW-2:0], quo[HW-1]};
        trial    = {1'b0, rem_sh[HW-1:0]} - {1'b0, dvs};
        trial_ok = ~trial[HW] | rem[HW-1];
        fin_q    = qneg ? HW'(-quo) : quo;
        fin_r    = rneg ? HW'(-rem[HW-1:0]) : rem[HW-1:0];
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        next_state  = state;
        next_regs   = regs;
        next_flags  = flags;
        next_cur    = cur;
        next_result = result;
        next_rem    = rem;
        next_quo    = quo;
        next_dvs    = dvs;
        next_cnt    = cnt;
        next_qneg   = qneg;
        next_rneg   = rneg;
        case (state)
            calu_pkg::CALU_ST_IDLE: begin
                if (req_valid_i && is_div) begin
                    next_cur  = req_i;
                    next_dvs  = div_abs_s;
                    next_qneg = div_sgn_d ^ div_sgn_s;
                    next_rneg = div_sgn_d;
                    if (req_i.size == calu_pkg::CALU_SZ_B) begin
                        next_rem = {24'h0, div_abs_d[HW-1:BW]};
                        next_quo = {div_abs_d[BW-1:0], 8'h0};
                        next_cnt = calu_pkg::DIV_STEPS_W'(BW);
                    end else begin
                        next_rem = {16'h0, div_abs_d[DW-1:HW]};
                        next_quo = div_abs_d[HW-1:0];
                        next_cnt = calu_pkg::DIV_STEPS_W'(HW);
                    end
                    if (div_abs_s == '0) begin
                        // Zero divisor: destination kept, overflow+zero flagged
                        next_flags.v = 1'b1;
                        next_flags.z = 1'b1;
                        next_result  = regs[req_i.dst[calu_pkg::REG_IDX_W-1:0]];
                        next_state   = calu_pkg::CALU_ST_DONE;
                    end else begin
                        next_state = calu_pkg::CALU_ST_DIV;
                    end
                end else if (req_valid_i) begin
                    next_cur   = req_i;
                    next_flags = fl;
                    next_result = res;
                    if (wr_en)
                        next_regs[req_i.dst[calu_pkg::REG_IDX_W-1:0]] =
                            wr_view(regs[req_i.dst[calu_pkg::REG_IDX_W-1:0]], res,
                                    req_i.dst[calu_pkg::REG_IDX_W], req_i.size);
                    next_state = calu_pkg::CALU_ST_DONE;
                end
            end
            calu_pkg::CALU_ST_DIV: begin
                next_rem = trial_ok ? {16'h0, trial[HW-1:0]} : rem_sh;
                next_quo = {quo[HW-2:0], trial_ok};
                next_cnt = cnt - calu_pkg::DIV_STEPS_W'(1);
                if (cnt == calu_pkg::DIV_STEPS_W'(1)) next_state = calu_pkg::CALU_ST_DONE;
                if (byte_div) begin
                    next_rem = trial_ok ? {24'h0, trial[BW-1:0]} : {24'h0, rem_sh[BW-1:0]};
                end
            end
            calu_pkg::CALU_ST_DONE: begin
                if (cur.op inside {calu_pkg::CALU_OP_UDIV, calu_pkg::CALU_OP_SDIV} && cnt == '0) begin
                    next_result = byte_div ? {16'h0, fin_r[BW-1:0], fin_q[BW-1:0]} :
                                             {fin_r, fin_q};
                    next_flags.n = byte_div ? fin_q[BW-1] : fin_q[HW-1];
                    next_flags.z = byte_div ? fin_q[BW-1:0] == '0 : fin_q == '0;
                    next_regs[cur.dst[calu_pkg::REG_IDX_W-1:0]] =
                        wr_view(regs[cur.dst[calu_pkg::REG_IDX_W-1:0]], next_result,
                                cur.dst[calu_pkg::REG_IDX_W],
                                byte_div ? calu_pkg::CALU_SZ_W : calu_pkg::CALU_SZ_L);
                    next_cnt = calu_pkg::DIV_STEPS_W'(1);
                end else begin
                    next_cur.op = calu_pkg::CALU_OP_COMP;
                    next_state  = calu_pkg::CALU_ST_IDLE;
                end
            end
            default: next_state = calu_pkg::CALU_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < int'(REG_CNT); i++) regs[i] <= '0;
            state  <= calu_pkg::CALU_ST_IDLE;
            flags  <= calu_pkg::FLAGS_RESET;
            cur    <= '0;
            result <= '0;
            rem    <= '0;
            quo    <= '0;
            dvs    <= '0;
            cnt    <= '0;
            qneg   <= 1'b0;
            rneg   <= 1'b0;
        end else begin
            regs   <= next_regs;
            state  <= next_state;
            flags  <= next_flags;
            cur    <= next_cur;
            result <= next_result;
            rem    <= next_rem;
            quo    <= next_quo;
            dvs    <= next_dvs;
            cnt    <= next_cnt;
            qneg   <= next_qneg;
            rneg   <= next_rneg;
        end
    end

    assign req_ready_o = state == calu_pkg::CALU_ST_IDLE;
    assign done_o      = state == calu_pkg::CALU_ST_DONE && next_state == calu_pkg::CALU_ST_IDLE;
    assign flags_o     = flags;
    assign result_o    = result;
    assign rd_data_o   = regs[rd_idx_i];

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_compare_keeps_dst;
        @(posedge clk_i) disable iff (!reset_n_i)
        (req_ready_o && req_valid_i && req_i.op == calu_pkg::CALU_OP_COMP)
        |=> regs[$past(req_i.dst[calu_pkg::REG_IDX_W-1:0])] ==
            $past(regs[req_i.dst[calu_pkg::REG_IDX_W-1:0]]);
    endproperty
    a_compare_keeps_dst: assert property (p_compare_keeps_dst) else $error("compare wrote dst");

    property p_bit_test_z;
        @(posedge clk_i) disable iff (!reset_n_i)
        (req_ready_o && req_valid_i && req_i.op == calu_pkg::CALU_OP_TSTB)
        |=> flags.z == !$past(sel_bit);
    endproperty
    a_bit_test_z: assert property (p_bit_test_z) else $error("bit test z wrong");

    property p_band_c;
        @(posedge clk_i) disable iff (!reset_n_i)
        (req_ready_o && req_valid_i && req_i.op == calu_pkg::CALU_OP_BAND)
        |=> flags.c == ($past(flags.c) & $past(sel_bit));
    endproperty
    a_band_c: assert property (p_band_c) else $error("bit and carry wrong");

    property p_inv_band_c;
        @(posedge clk_i) disable iff (!reset_n_i)
        (req_ready_o && req_valid_i && req_i.op == calu_pkg::CALU_OP_IBAND)
        |=> flags.c == ($past(flags.c) & !$past(sel_bit));
    endproperty
    a_inv_band_c: assert property (p_inv_band_c) else $error("inverted bit and wrong");

    property p_neg_res;
        @(posedge clk_i) disable iff (!reset_n_i)
        (req_ready_o && req_valid_i && req_i.op == calu_pkg::CALU_OP_NEG)
        |=> ((result + $past(dv)) & $past(mask)) == '0;
    endproperty
    a_neg_res: assert property (p_neg_res) else $error("negate result wrong");

    sequence s_div_start;
        req_ready_o && req_valid_i && is_div && div_abs_s != '0;
    endsequence
    property p_div_len;
        @(posedge clk_i) disable iff (!reset_n_i)
        s_div_start |=> !req_ready_o ##[8:18] done_o;
    endproperty
    a_div_len: assert property (p_div_len) else $error("divide did not finish");

    property p_done_once;
        @(posedge clk_i) disable iff (!reset_n_i)
        done_o |=> !done_o;
    endproperty
    a_done_once: assert property (p_done_once) else $error("done held");

    property p_ready_after_done;
        @(posedge clk_i) disable iff (!reset_n_i)
        done_o |=> req_ready_o;
    endproperty
    a_ready_after_done: assert property (p_ready_after_done) else $error("not ready");

endmodule : calu_core

// ### bench/calu_core_tb.sv
// Self-checking bench for the arithmetic, logic and bit datapath
`timescale 1ns/1ps
module calu_core_tb;
    logic                     clk_i       = 1'b0;
    logic                     reset_n_i   = 1'b0;
    logic                     req_valid_i = 1'b0;
    calu_pkg::calu_req_type   req_i       = '0;
    logic [2:0]               rd_idx_i    = 3'h0;
    logic                     req_ready_o;
    logic                     done_o;
    calu_pkg::calu_flags_type flags_o;
    logic [31:0]              result_o, rd_data_o, a, b, c, e, dvd, dvs;
    logic [31:0]              lfsr = 32'h00010c30;
    int                       n_fail = 0, num_checks = 0;
    always #50 clk_i = ~clk_i;
    calu_core calu_core_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .flags_o(flags_o),
        .result_o(result_o), .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : next_rand
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic run(input calu_pkg::calu_op_type op, input calu_pkg::calu_size_type sz,
                       input logic [3:0] dst, input logic [3:0] src, input logic u,
                       input logic [31:0] imm, input logic [2:0] bn);
        int n;
        @(negedge clk_i);
        req_i = '{op:op, size:sz, dst:dst, src:src, use_imm:u, imm:imm,
                  bit_from_reg:1'b0, bit_imm:bn};
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 40) n_fail++;
        @(negedge clk_i);
    endtask : run
    task automatic ld(input logic [3:0] r, input logic [31:0] v);
        run(calu_pkg::CALU_OP_AND, calu_pkg::CALU_SZ_L, r, 4'h0, 1'b1, 32'h0, 3'h0);
        run(calu_pkg::CALU_OP_OR, calu_pkg::CALU_SZ_L, r, 4'h0, 1'b1, v, 3'h0);
    endtask : ld
    task automatic rd_check(input logic [2:0] r, input logic [31:0] exp);
        rd_idx_i = r;
        #1;
        check(rd_data_o, exp);
    endtask : rd_check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        #2000000;
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (12) @(negedge clk_i);
        reset_n_i = 1'b1;
        for (int i = 0; i < 20; i++) begin
            a = next_rand();
            b = next_rand();
            c = a ^ b;
            ld(4'h1, a);
            run(calu_pkg::CALU_OP_XOR, calu_pkg::CALU_SZ_L, 4'h1, 4'h0, 1'b1, b, 3'h0);
            rd_check(3'h1, c);
            ld(4'h2, b);
            run(calu_pkg::CALU_OP_AND, calu_pkg::CALU_SZ_W, 4'h1, 4'h2, 1'b0, 32'h0, 3'h0);
            c[15:0] = c[15:0] & b[15:0];
            rd_check(3'h1, c);
            rd_check(3'h2, b);
            run(calu_pkg::CALU_OP_NEG, calu_pkg::CALU_SZ_B, 4'h9, 4'h0, 1'b1, 32'h0, 3'h0);
            c[7:0] = 8'h00 - c[7:0];
            rd_check(3'h1, c);
            run(calu_pkg::CALU_OP_NOT, calu_pkg::CALU_SZ_W, 4'h9, 4'h0, 1'b1, 32'h0, 3'h0);
            c[31:16] = ~c[31:16];
            rd_check(3'h1, c);
            run(calu_pkg::CALU_OP_SETB, calu_pkg::CALU_SZ_B, 4'h9, 4'h0, 1'b1, 32'h0, a[2:0]);
            c[a[2:0]] = 1'b1;
            rd_check(3'h1, c);
            run(calu_pkg::CALU_OP_TSTB, calu_pkg::CALU_SZ_B, 4'h9, 4'h0, 1'b1, 32'h0, a[2:0]);
            check({31'h0, flags_o.z}, 32'h0);
            run(calu_pkg::CALU_OP_COMP, calu_pkg::CALU_SZ_L, 4'h1, 4'h0, 1'b1, c, 3'h0);
            check({31'h0, flags_o.z}, 32'h1);
            rd_check(3'h1, c);
            run(calu_pkg::CALU_OP_ASR, calu_pkg::CALU_SZ_L, 4'h2, 4'h0, 1'b1, 32'h0, 3'h0);
            e = {b[31], b[31:1]};
            rd_check(3'h2, e);
            run(calu_pkg::CALU_OP_SEXT, calu_pkg::CALU_SZ_W, 4'h2, 4'h0, 1'b1, 32'h0, 3'h0);
            e[15:8] = {8{e[7]}};
            rd_check(3'h2, e);
            dvd = {31'h0, e[7]};
            run(calu_pkg::CALU_OP_ROLC, calu_pkg::CALU_SZ_B, 4'ha, 4'h0, 1'b1, 32'h0, 3'h0);
            e[7:0] = {e[6:0], b[0]};
            rd_check(3'h2, e);
            check({31'h0, flags_o.c}, dvd);
            run(calu_pkg::CALU_OP_IBAND, calu_pkg::CALU_SZ_B, 4'ha, 4'h0, 1'b1, 32'h0, 3'h0);
            check({31'h0, flags_o.c}, {31'h0, dvd[0] & ~e[0]});
            run(calu_pkg::CALU_OP_CLRB, calu_pkg::CALU_SZ_B, 4'ha, 4'h0, 1'b1, 32'h0, a[2:0]);
            e[a[2:0]] = 1'b0;
            rd_check(3'h2, e);
            dvs = {16'h0, b[15:0] | 16'h8000};
            dvd = {a[31:16] & 16'h7fff, a[15:0]};
            ld(4'h3, dvs);
            ld(4'h4, dvd);
            run(calu_pkg::CALU_OP_UDIV, calu_pkg::CALU_SZ_W, 4'h4, 4'h3, 1'b0, 32'h0, 3'h0);
            e = dvd % dvs;
            rd_check(3'h4, {e[15:0], 16'(dvd / dvs)});
            check(result_o, {e[15:0], 16'(dvd / dvs)});
            dvs = {24'h0, 2'b01, b[5:0]};
            dvd = 32'h0 - {19'h0, a[12:0]};
            ld(4'h5, dvs);
            ld(4'h6, dvd);
            run(calu_pkg::CALU_OP_SDIV, calu_pkg::CALU_SZ_B, 4'h6, 4'hd, 1'b0, 32'h0, 3'h0);
            e = {dvd[31:16], 8'($signed(dvd[15:0]) % $signed(dvs[15:0])),
                 8'($signed(dvd[15:0]) / $signed(dvs[15:0]))};
            rd_check(3'h6, e);
            run(calu_pkg::CALU_OP_UDIV, calu_pkg::CALU_SZ_W, 4'h6, 4'h7, 1'b0, 32'h0, 3'h0);
            rd_check(3'h6, e);
            check({30'h0, flags_o.z, flags_o.v}, 32'h3);
        end
        complete_run();
    end
endmodule : calu_core_tb
